// ==== i2c_irq_map.svh ====
`ifndef I2C_IRQ_MAP_SVH
`define I2C_IRQ_MAP_SVH

`define OFS_IRQ_RAW_FLAGS 6'h00
`define OFS_IRQ_GATE 6'h04
`define OFS_IRQ_WIPE 6'h08
`define OFS_BUS_SETUP_A 6'h0C
`define OFS_BUS_SETUP_B 6'h10
`define OFS_BUS_SETUP_C 6'h14
`define OFS_OWN_BUS_IDENTIFIER 6'h18
`define OFS_TRANSFER_PAYLOAD 6'h1C
`define OFS_PEER_LOCATION 6'h20
`define OFS_COMMAND_TRIGGER 6'h24
`define MAP_ADDR_W 6

`define BIT_ARB_LOST 3
`define BIT_NO_ACK 2
`define BIT_STOP_DONE 1
`define BIT_ACK_DONE 0
`define FLAG_W 4

`define RST_IRQ_RAW_FLAGS 4'h0
`define RST_IRQ_GATE 4'hF
`define RST_SETUP_WORD 32'h0000_0000

`define READ_WAIT_CYCLES 1

`endif

// ==== i2c_irq_pkg.sv ====
package i2c_irq_pkg;
	typedef logic [3:0] irq_vec_t;
	typedef logic [31:0] word_t;
	typedef enum logic [0:0] {
		ANS_IDLE = 1'b0,
		ANS_HELD = 1'b1
	} answer_state_e;
endpackage

// ==== irq_link_if.sv ====
`timescale 1ns/100ps
interface irq_link_if;
	i2c_irq_pkg::irq_vec_t events;
	i2c_irq_pkg::irq_vec_t raw;
	i2c_irq_pkg::irq_vec_t gate;
	i2c_irq_pkg::irq_vec_t wipe_bits;
	i2c_irq_pkg::irq_vec_t gate_bits;
	logic wipe_wr;
	logic gate_wr;
	logic irq;
	modport bank (output events, wipe_bits, wipe_wr, gate_bits, gate_wr,
		input raw, gate, irq);
	modport flags (input events, wipe_bits, wipe_wr, gate_bits, gate_wr,
		output raw, gate, irq);
endinterface

interface answer_link_if;
	logic read_req;
	logic wait_req;
	logic capture;
	modport bank (output read_req, input wait_req, capture);
	modport pacer (input read_req, output wait_req, capture);
endinterface

// ==== irq_flags.sv ====
`timescale 1ns/100ps
`include "i2c_irq_map.svh"
module irq_flags (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	irq_link_if.flags lnk
);
	i2c_irq_pkg::irq_vec_t raw_reg;
	i2c_irq_pkg::irq_vec_t raw_next;
	i2c_irq_pkg::irq_vec_t gate_reg;
	i2c_irq_pkg::irq_vec_t wipe_eff;

	// Set beats clear so an event in the clearing cycle survives
	always_comb begin
		wipe_eff = lnk.wipe_wr ? lnk.wipe_bits : `RST_IRQ_RAW_FLAGS;
		raw_next = (raw_reg & ~wipe_eff) | lnk.events;
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			raw_reg <= `RST_IRQ_RAW_FLAGS;
		end else begin
			raw_reg <= raw_next;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gate_reg <= `RST_IRQ_GATE;
		end else if (lnk.gate_wr) begin
			gate_reg <= lnk.gate_bits;
		end
	end

	assign lnk.raw = raw_reg;
	assign lnk.gate = gate_reg;
	assign lnk.irq = |(raw_reg & ~gate_reg);

	property p_sticky;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		1'b1 |=> ((($past(raw_reg) & ~$past(wipe_eff)) & ~raw_reg) == 4'h0);
	endproperty
	AST_RAW_STICKY: assert property (p_sticky)
		else $error("raw flag dropped without a clear");

	property p_event_sets;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(lnk.events != 4'h0) |=> ((raw_reg & $past(lnk.events)) == $past(lnk.events));
	endproperty
	AST_EVENT_SETS: assert property (p_event_sets)
		else $error("event did not set its flag");

	property p_wipe;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		lnk.wipe_wr |=> ((raw_reg & $past(lnk.wipe_bits) & ~$past(lnk.events)) == 4'h0);
	endproperty
	AST_WIPE_CLEARS: assert property (p_wipe)
		else $error("clear write left a flag set");
endmodule

// ==== bus_answer.sv ====
`timescale 1ns/100ps
module bus_answer (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	answer_link_if.pacer ans
);
	i2c_irq_pkg::answer_state_e state_reg;
	i2c_irq_pkg::answer_state_e state_next;

	// One wait cycle lets read data come from a flop
	always_comb begin
		case (state_reg)
			i2c_irq_pkg::ANS_IDLE: begin
				state_next = ans.read_req ? i2c_irq_pkg::ANS_HELD : i2c_irq_pkg::ANS_IDLE;
			end
			i2c_irq_pkg::ANS_HELD: begin
				state_next = i2c_irq_pkg::ANS_IDLE;
			end
			default: begin
				state_next = i2c_irq_pkg::ANS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= i2c_irq_pkg::ANS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign ans.capture = ans.read_req && (state_reg == i2c_irq_pkg::ANS_IDLE);
	assign ans.wait_req = ans.capture;
endmodule

// ==== i2c_interrupt_register_bank.sv ====
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
`include "i2c_irq_map.svh"
// How it works
// - Ten 32-bit registers sit at byte offsets 0x00 to 0x24, clear and command write-only.
// - Offset 0x00 reads the raw event flags, untouched by the mask.
// - Bit 3 sets when another master wins arbitration.
// - Bit 2 sets when the peer identifier or write data goes unacknowledged.
// - Bit 1 sets once the stop sequence has finished on the serial bus.
// - Bit 0 sets when the peripheral acknowledges the current phase.
// - Offset 0x04 holds one mask bit per event in the same positions.
// - A mask bit of one blocks its event, and all mask bits reset to one.
// - The interrupt output is high while any unmasked flag is set.
// - Writing one to a bit at offset 0x08 clears the matching flag.
// - Flags and clear reset to zero, bits 31 to 4 are reserved.
module i2c_interrupt_register_bank #(
	parameter int ADDR_W = `MAP_ADDR_W
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic evt_arb_lost_i,
	input wire logic evt_no_ack_i,
	input wire logic evt_stop_done_i,
	input wire logic evt_ack_done_i,
	output logic irq_o,
	output logic [31:0] bus_setup_a_o,
	output logic [31:0] bus_setup_b_o,
	output logic [31:0] bus_setup_c_o,
	output logic [31:0] own_bus_identifier_o,
	output logic [31:0] transfer_payload_o,
	output logic [31:0] peer_location_o,
	output logic [31:0] command_word_o,
	output logic command_strobe_o
);
	if (ADDR_W < `MAP_ADDR_W) begin : g_addr_check
		$error("ADDR_W too narrow for the register map");
	end

	irq_link_if lnk ();
	answer_link_if ans ();

	i2c_irq_pkg::word_t setup_a_reg;
	i2c_irq_pkg::word_t setup_b_reg;
	i2c_irq_pkg::word_t setup_c_reg;
	i2c_irq_pkg::word_t own_id_reg;
	i2c_irq_pkg::word_t payload_reg;
	i2c_irq_pkg::word_t peer_reg;
	i2c_irq_pkg::word_t command_reg;
	logic command_strobe_reg;
	i2c_irq_pkg::word_t readdata_reg;
	i2c_irq_pkg::word_t rd_word;
	logic wr_acc;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction

	function automatic i2c_irq_pkg::word_t merge(input i2c_irq_pkg::word_t old,
		input i2c_irq_pkg::word_t wd, input logic [3:0] be);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction

	irq_flags u_flags (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.lnk(lnk)
	);

	bus_answer u_answer (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.ans(ans)
	);

	// Writes never wait; only reads take the extra cycle
	assign wr_acc = avs_write_i && !avs_read_i;
	assign ans.read_req = avs_read_i && !avs_write_i;
	assign avs_waitrequest_o = ans.wait_req;

	always_comb begin
		lnk.events = 4'h0;
		lnk.events[`BIT_ARB_LOST] = evt_arb_lost_i;
		lnk.events[`BIT_NO_ACK] = evt_no_ack_i;
		lnk.events[`BIT_STOP_DONE] = evt_stop_done_i;
		lnk.events[`BIT_ACK_DONE] = evt_ack_done_i;
	end

	// Only byte lane 0 carries interrupt bits; upper lanes are dropped
	assign lnk.wipe_wr = wr_acc && hit(avs_address_i, `OFS_IRQ_WIPE)
		&& avs_byteenable_i[0];
	assign lnk.wipe_bits = avs_writedata_i[`FLAG_W-1:0];
	assign lnk.gate_wr = wr_acc && hit(avs_address_i, `OFS_IRQ_GATE)
		&& avs_byteenable_i[0];
	assign lnk.gate_bits = avs_writedata_i[`FLAG_W-1:0];
	assign irq_o = lnk.irq;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			setup_a_reg <= `RST_SETUP_WORD;
			setup_b_reg <= `RST_SETUP_WORD;
			setup_c_reg <= `RST_SETUP_WORD;
			own_id_reg <= `RST_SETUP_WORD;
			payload_reg <= `RST_SETUP_WORD;
			peer_reg <= `RST_SETUP_WORD;
		end else if (wr_acc) begin
			if (hit(avs_address_i, `OFS_BUS_SETUP_A)) begin
				setup_a_reg <= merge(setup_a_reg, avs_writedata_i, avs_byteenable_i);
			end
			if (hit(avs_address_i, `OFS_BUS_SETUP_B)) begin
				setup_b_reg <= merge(setup_b_reg, avs_writedata_i, avs_byteenable_i);
			end
			if (hit(avs_address_i, `OFS_BUS_SETUP_C)) begin
				setup_c_reg <= merge(setup_c_reg, avs_writedata_i, avs_byteenable_i);
			end
			if (hit(avs_address_i, `OFS_OWN_BUS_IDENTIFIER)) begin
				own_id_reg <= merge(own_id_reg, avs_writedata_i, avs_byteenable_i);
			end
			if (hit(avs_address_i, `OFS_TRANSFER_PAYLOAD)) begin
				payload_reg <= merge(payload_reg, avs_writedata_i, avs_byteenable_i);
			end
			if (hit(avs_address_i, `OFS_PEER_LOCATION)) begin
				peer_reg <= merge(peer_reg, avs_writedata_i, avs_byteenable_i);
			end
		end
	end

	// Command strobe lasts one cycle so the engine sees each write once
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			command_reg <= `RST_SETUP_WORD;
			command_strobe_reg <= 1'b0;
		end else begin
			command_strobe_reg <= wr_acc && hit(avs_address_i, `OFS_COMMAND_TRIGGER);
			if (wr_acc && hit(avs_address_i, `OFS_COMMAND_TRIGGER)) begin
				command_reg <= merge(command_reg, avs_writedata_i, avs_byteenable_i);
			end
		end
	end

	// Write-only and unmapped offsets read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (1'b1)
			hit(avs_address_i, `OFS_IRQ_RAW_FLAGS): begin
				rd_word = {28'h000_0000, lnk.raw};
			end
			hit(avs_address_i, `OFS_IRQ_GATE): begin
				rd_word = {28'h000_0000, lnk.gate};
			end
			hit(avs_address_i, `OFS_BUS_SETUP_A): begin
				rd_word = setup_a_reg;
			end
			hit(avs_address_i, `OFS_BUS_SETUP_B): begin
				rd_word = setup_b_reg;
			end
			hit(avs_address_i, `OFS_BUS_SETUP_C): begin
				rd_word = setup_c_reg;
			end
			hit(avs_address_i, `OFS_OWN_BUS_IDENTIFIER): begin
				rd_word = own_id_reg;
			end
			hit(avs_address_i, `OFS_TRANSFER_PAYLOAD): begin
				rd_word = payload_reg;
			end
			hit(avs_address_i, `OFS_PEER_LOCATION): begin
				rd_word = peer_reg;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			readdata_reg <= 32'h0000_0000;
		end else if (ans.capture) begin
			readdata_reg <= rd_word;
		end
	end

	assign avs_readdata_o = readdata_reg;
	assign bus_setup_a_o = setup_a_reg;
	assign bus_setup_b_o = setup_b_reg;
	assign bus_setup_c_o = setup_c_reg;
	assign own_bus_identifier_o = own_id_reg;
	assign transfer_payload_o = payload_reg;
	assign peer_location_o = peer_reg;
	assign command_word_o = command_reg;
	assign command_strobe_o = command_strobe_reg;

	sequence s_read_start;
		avs_read_i && avs_waitrequest_o;
	endsequence

	sequence s_read_done(logic [5:0] ofs);
		avs_read_i && !avs_waitrequest_o && hit(avs_address_i, ofs);
	endsequence

	property p_read_one_wait;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_read_start ##1 avs_read_i |-> !avs_waitrequest_o;
	endproperty
	AST_READ_ONE_WAIT: assert property (p_read_one_wait)
		else $error("read answer not after one wait cycle");

	property p_raw_read;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_read_done(`OFS_IRQ_RAW_FLAGS) |-> (avs_readdata_o == {28'h000_0000, $past(lnk.raw)});
	endproperty
	AST_RAW_READ: assert property (p_raw_read)
		else $error("source read differs from raw flags");

	property p_gate_read;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_read_done(`OFS_IRQ_GATE) |-> (avs_readdata_o[31:4] == 28'h000_0000);
	endproperty
	AST_RESERVED_ZERO: assert property (p_gate_read)
		else $error("reserved mask bits read nonzero");

	property p_wipe_read;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_read_done(`OFS_IRQ_WIPE) or s_read_done(`OFS_COMMAND_TRIGGER)
		|-> (avs_readdata_o == 32'h0000_0000);
	endproperty
	AST_WO_READ_ZERO: assert property (p_wipe_read)
		else $error("write-only register read nonzero");

	property p_gate_write;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		lnk.gate_wr |=> (lnk.gate == $past(avs_writedata_i[3:0]));
	endproperty
	AST_MASK_WRITE: assert property (p_gate_write)
		else $error("mask write not stored");

	property p_gate_reset;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		$rose(rst_b_i) |-> (lnk.gate == 4'hF && lnk.raw == 4'h0);
	endproperty
	AST_RESET_VALUES: assert property (p_gate_reset)
		else $error("wrong interrupt reset values");

	property p_irq;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		irq_o == ((lnk.raw & ~lnk.gate) != 4'h0);
	endproperty
	AST_IRQ_OUT: assert property (p_irq)
		else $error("interrupt output disagrees with flags and mask");

	property p_event_irq;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(evt_stop_done_i && !lnk.gate[`BIT_STOP_DONE] && !lnk.gate_wr) |=> irq_o;
	endproperty
	AST_STOP_RAISES_IRQ: assert property (p_event_irq)
		else $error("unmasked stop event did not raise interrupt");

	sequence s_cmd_write;
		avs_write_i && !avs_read_i && hit(avs_address_i, `OFS_COMMAND_TRIGGER);
	endsequence

	property p_cmd_pulse;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_cmd_write |=> command_strobe_o;
	endproperty
	AST_CMD_STROBE: assert property (p_cmd_pulse)
		else $error("command write gave no strobe");

	// Strobe may only repeat for a fresh command write
	property p_cmd_single;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(command_strobe_o && !(wr_acc && hit(avs_address_i, `OFS_COMMAND_TRIGGER)))
		|=> !command_strobe_o;
	endproperty
	AST_CMD_ONE_CYCLE: assert property (p_cmd_single)
		else $error("command strobe longer than one cycle");

	property p_cmd_word;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(s_cmd_write ##0 (avs_byteenable_i == 4'hF))
		|=> (command_word_o == $past(avs_writedata_i));
	endproperty
	AST_CMD_WORD: assert property (p_cmd_word)
		else $error("command word not stored");

	property p_write_no_wait;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		avs_write_i |-> !avs_waitrequest_o;
	endproperty
	AST_WRITE_NO_WAIT: assert property (p_write_no_wait)
		else $error("write was held off");

	property p_setup_write;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(wr_acc && hit(avs_address_i, `OFS_BUS_SETUP_A) && (avs_byteenable_i == 4'hF))
		|=> (bus_setup_a_o == $past(avs_writedata_i));
	endproperty
	AST_SETUP_WRITE: assert property (p_setup_write)
		else $error("setup word not stored");

	// Mask changes only through its own write
	property p_gate_hold;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		!lnk.gate_wr |=> (lnk.gate == $past(lnk.gate));
	endproperty
	AST_MASK_HOLDS: assert property (p_gate_hold)
		else $error("mask changed without a mask write");
endmodule

// ==== i2c_peer_model.sv ====
`timescale 1ns/100ps
module i2c_peer_model (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] evt_req_i,
	input wire logic start_i,
	input wire logic [7:0] lag_i,
	output logic [3:0] evt_o
);
	logic [7:0] lag_reg;
	// Serial bus is slow, so stop completes lag_i cycles after a start
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lag_reg <= 8'h00;
		end else if (start_i) begin
			lag_reg <= lag_i;
		end else if (lag_reg != 8'h00) begin
			lag_reg <= lag_reg - 8'h01;
		end
	end
	// Lost arbitration, missing or given acknowledge when asked
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			evt_o <= 4'h0;
		end else begin
			evt_o <= evt_req_i | {2'b00, lag_reg == 8'h01, 1'b0};
		end
	end
endmodule

// ==== i2c_interrupt_register_bank_tb.sv ====
`timescale 1ns/100ps
`include "i2c_irq_map.svh"
module i2c_interrupt_register_bank_tb;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [5:0] adr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] be = 4'h0;
	logic [3:0] evt_req = 4'h0;
	logic [3:0] evt;
	logic [7:0] lag = 8'h01;
	logic wait_o, irq, strobe;
	i2c_irq_pkg::word_t cfg [6];
	i2c_irq_pkg::word_t cmdq[$];
	i2c_irq_pkg::word_t wdat = 32'h0000_0000;
	i2c_irq_pkg::word_t rdat, cmd_word;
	logic [31:0] seed = 32'hF065CE69;
	i2c_irq_pkg::word_t expq[$];
	int err_count = 0;
	int n_checks = 0;

	always #12.5 sys_clk_i = ~sys_clk_i;

	i2c_interrupt_register_bank dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
		.evt_arb_lost_i(evt[3]), .evt_no_ack_i(evt[2]), .evt_stop_done_i(evt[1]),
		.evt_ack_done_i(evt[0]), .irq_o(irq), .bus_setup_a_o(cfg[0]),
		.bus_setup_b_o(cfg[1]), .bus_setup_c_o(cfg[2]), .own_bus_identifier_o(cfg[3]),
		.transfer_payload_o(cfg[4]), .peer_location_o(cfg[5]),
		.command_word_o(cmd_word), .command_strobe_o(strobe));

	i2c_peer_model peer (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .evt_req_i(evt_req),
		.start_i(strobe), .lag_i(lag), .evt_o(evt));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
	endfunction

	task automatic chk(input i2c_irq_pkg::word_t seen, input i2c_irq_pkg::word_t exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic hang();
		err_count++;
		$display("BAD %0t no answer in time", $time);
		wrap_up();
	endtask

	// Request held until waitrequest is seen low at an edge
	task automatic xfer(input logic w, input logic [5:0] a, input i2c_irq_pkg::word_t d,
		input logic [3:0] b);
		int n;
		rd <= ~w;
		wr <= w;
		adr <= a;
		wdat <= d;
		be <= b;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk_i);
			if (wait_o === 1'b0) break;
		end
		if (n == 20) hang();
		rd <= 1'b0;
		wr <= 1'b0;
		// Idle edge so the next call never reassigns in this step
		@(posedge sys_clk_i);
	endtask

	task automatic wr_reg(input logic [5:0] a, input i2c_irq_pkg::word_t d,
		input logic [3:0] b);
		xfer(1'b1, a, d, b);
	endtask

	task automatic rd_reg(input logic [5:0] a, input i2c_irq_pkg::word_t exp);
		expq.push_back(exp);
		xfer(1'b0, a, wdat, 4'hF);
	endtask

	task automatic fire(input logic [3:0] e);
		evt_req <= e;
		@(posedge sys_clk_i);
		evt_req <= 4'h0;
		repeat (3) @(posedge sys_clk_i);
	endtask

	// Read results are judged where they appear, oldest note first
	always @(posedge sys_clk_i) begin
		if (rd && wait_o === 1'b0) begin
			if (expq.size() == 0) begin
				hang();
			end else begin
				chk(rdat, expq.pop_front());
			end
		end
	end

	// A strobe with no pending command note is an extra pulse
	always @(posedge sys_clk_i) begin
		if (strobe === 1'b1) begin
			chk({31'h0, cmdq.size() != 0}, 32'h1);
			if (cmdq.size() != 0) begin
				chk(cmd_word, cmdq.pop_front());
			end
		end
	end

	initial begin
		int i, n;
		repeat (12) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_reg(`OFS_IRQ_RAW_FLAGS, 32'h0);
		rd_reg(`OFS_IRQ_GATE, 32'hF);
		rd_reg(`OFS_IRQ_WIPE, 32'h0);
		rd_reg(`OFS_COMMAND_TRIGGER, 32'h0);
		rd_reg(6'h28, 32'h0);
		chk({31'h0, irq}, 32'h0);
		for (i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr_reg(`OFS_BUS_SETUP_A + 6'(4 * i), seed, 4'hF);
			rd_reg(`OFS_BUS_SETUP_A + 6'(4 * i), seed);
			chk(cfg[i], seed);
		end
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			fire(4'h1 << i);
			rd_reg(`OFS_IRQ_RAW_FLAGS, 32'h1 << i);
			wr_reg(`OFS_IRQ_WIPE, {seed[31:4], 4'h0}, 4'hF);
			rd_reg(`OFS_IRQ_RAW_FLAGS, 32'h1 << i);
			wr_reg(`OFS_IRQ_WIPE, {seed[31:4], 4'h1 << i}, 4'hF);
			rd_reg(`OFS_IRQ_RAW_FLAGS, 32'h0);
		end
		fire(4'hF);
		rd_reg(`OFS_IRQ_RAW_FLAGS, 32'hF);
		chk({31'h0, irq}, 32'h0);
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr_reg(`OFS_IRQ_GATE, {seed[31:4], ~(4'h1 << i)}, 4'hF);
			chk({31'h0, irq}, 32'h1);
			rd_reg(`OFS_IRQ_GATE, {28'h0, ~(4'h1 << i)});
			wr_reg(`OFS_IRQ_GATE, 32'hF, 4'hF);
			chk({31'h0, irq}, 32'h0);
		end
		// Lane 0 off leaves the mask alone
		wr_reg(`OFS_IRQ_GATE, 32'h0, 4'hE);
		rd_reg(`OFS_IRQ_GATE, 32'hF);
		wr_reg(`OFS_IRQ_WIPE, 32'hF, 4'hF);
		wr_reg(`OFS_IRQ_GATE, 32'hD, 4'hF);
		// Prompt then slow stop; a new start waits for the stop flag
		for (i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			lag <= i ? 8'h28 : 8'h01;
			cmdq.push_back(seed);
			wr_reg(`OFS_COMMAND_TRIGGER, seed, 4'hF);
			chk({31'h0, irq}, 32'h0);
			for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge sys_clk_i);
			if (n == 100) hang();
			chk(32'(cmdq.size()), 32'h0);
			rd_reg(`OFS_IRQ_RAW_FLAGS, 32'h2);
			wr_reg(`OFS_IRQ_WIPE, 32'h2, 4'hF);
			chk({31'h0, irq}, 32'h0);
		end
		wrap_up();
	end
endmodule
